// File: core/rfr_regs.sv
// radio receiver, synthesizer and strobe processor register bank
`timescale 1ns/10ps
module rfr_regs import rfr_pkg::*; #(
  parameter int unsigned ADDR_W = 18
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // synthesizer pins, inputs asynchronous
  input wire logic synth_on,
  input wire logic ref_clk_lvl,
  input wire logic sync_ok,
  input wire logic pre_clk_lvl,
  input wire logic cal_busy,
  output logic lock_window,
  output logic pll_locked,
  output logic [11:0] rf_word,
  output logic [11:0] lo_word,
  // receiver
  input wire logic receive_active,
  input wire rfr_agc_t agc_mode,
  output rfr_gain_t gain,
  // strobe processor, same clock
  input wire logic csp_running,
  input wire logic mac_overflow,
  input wire rfr_op_t csp_op,
  input wire logic [7:0] csp_operand,
  input wire logic [7:0] csp_random,
  output logic [7:0] csp_x,
  output logic [7:0] csp_y,
  output logic [7:0] csp_z,
  output logic cpu_ctrl,
  output logic csp_stop
);
  // the index decode below needs sixteen index bits
  if (ADDR_W < 18) begin : g_chk
    $error("ADDR_W must be at least 18");
  end

  rfr_state_t st; // registered state
  rfr_state_t next_st; // next state

  // ***************************************************
  // register read mux, also used as the address decode
  // ***************************************************
  function automatic logic [8:0] rd_reg(input logic [ADDR_W-1:0] a,
                                        input rfr_state_t s);
    logic [15:0] idx;
    logic [8:0] r;
    idx = a[17:2];
    r = 9'h000;
    if (a[1:0] == 2'b00) begin
      // bit 8 flags a mapped register
      unique case (idx)
        IDX_LNA_MODE: r = {1'b1, s.low_noise_amplifier};
        IDX_FILT_GAIN: r = {3'b100, s.filt};
        IDX_MIXER: r = {1'b1, s.mix};
        IDX_SYN_HI: r = {1'b1, s.thr, s.cal_done, s.cal_run, s.win_len,
                         s.locked, s.word[9:8]};
        IDX_SYN_LO: r = {1'b1, s.word[7:0]};
        IDX_CSP_X: r = {1'b1, s.x};
        IDX_CSP_Y: r = {1'b1, s.y};
        IDX_CSP_Z: r = {1'b1, s.z};
        IDX_CSP_CTRL: r = {8'h80, s.cpu_ctrl};
        IDX_CSP_T: r = {1'b1, s.t};
        default: r = 9'h000;
      endcase
    end
    return r;
  endfunction

  // ***************************************************
  // next state
  // ***************************************************
  always_comb begin
    logic wr;
    logic [8:0] hit;
    logic [7:0] d;
    logic ref_rise;
    logic pre_rise;
    logic [9:0] need;
    logic dec_t;
    wr = 1'b0;
    hit = 9'h000;
    d = pwdata[7:0];
    ref_rise = 1'b0;
    pre_rise = 1'b0;
    need = 10'h000;
    dec_t = 1'b0;
    next_st = st;
    hit = rd_reg(paddr, st);
    // a write lands only at the edge that completes the transfer
    wr = psel && penable && st.rd_ok && pwrite && pstrb[0] && hit[8];
    // capture read data once per transfer, normally at the setup edge;
    // if ce froze that edge the access phase captures it and waits a cycle
    if (!psel || (penable && st.rd_ok)) begin
      next_st.rd_ok = 1'b0;
    end else if (!st.rd_ok) begin
      next_st.prdata = {24'h000000, hit[7:0]};
      next_st.pslverr = !hit[8];
      next_st.rd_ok = 1'b1;
    end
    // two-flop synchronisers, third stage only for edges
    next_st.ref_s = {st.ref_s[1:0], ref_clk_lvl};
    next_st.pre_s = {st.pre_s[1:0], pre_clk_lvl};
    next_st.ok_s = {st.ok_s[0], sync_ok};
    next_st.on_s = {st.on_s[0], synth_on};
    next_st.cal_s = {st.cal_s[0], cal_busy};
    next_st.on_d = st.on_s[1];
    ref_rise = st.ref_s[1] && !st.ref_s[2];
    pre_rise = st.pre_s[1] && !st.pre_s[2];
    // lock detection on each reference period
    need = LOCK_BASE_PERIODS << st.thr;
    if (!st.on_s[1]) begin
      next_st.lock_cnt = 10'h000;
      next_st.locked = 1'b0;
    end else if (ref_rise) begin
      if (st.ok_s[1]) begin
        // count saturates, so lock holds while windows stay good
        if (st.lock_cnt + 10'd1 >= need) begin
          next_st.locked = 1'b1;
          next_st.lock_cnt = need;
        end else begin
          next_st.lock_cnt = st.lock_cnt + 10'd1;
        end
      end else begin
        // a failed window breaks the consecutive run
        next_st.lock_cnt = 10'h000;
        next_st.locked = 1'b0;
      end
    end
    // lock window opens at a reference edge
    if (!st.on_s[1]) begin
      // no prescaler edges arrive while off, so drop the window at once
      next_st.window = 1'b0;
    end else if (ref_rise) begin
      next_st.window = 1'b1;
      next_st.win_cnt = st.win_len ? WIN_LONG : WIN_SHORT;
    end else if (pre_rise && st.window) begin
      next_st.win_cnt = st.win_cnt - 3'd1;
      if (st.win_cnt == 3'd1) begin
        next_st.window = 1'b0;
      end
    end
    // calibration flags
    next_st.cal_run = st.cal_s[1];
    if (st.on_s[1] && !st.on_d) begin
      next_st.cal_done = 1'b0;
    end
    // completion set wins over a power-on clear
    if (st.cal_run && !st.cal_s[1]) begin
      next_st.cal_done = 1'b1;
    end
    // frequency words
    next_st.rf_word = CHANNEL_WORD_BASE + {2'b00, st.word};
    next_st.lo_word = CHANNEL_WORD_BASE + {2'b00, st.word}
                      - (receive_active ? RX_LO_OFFSET : 12'd0);
    // gain settings by agc mode
    next_st.gain.rx_mixer_drive = st.mix[1:0];
    next_st.gain.bpf_lo_cur = st.filt[5];
    next_st.gain.bpf_mid_cur = st.filt[4];
    unique case (agc_mode)
      AGC_HIGH: begin
        next_st.gain.amp_drive = st.low_noise_amplifier[5:4];
        next_st.gain.amp_reduced_gain = 1'b0;
        next_st.gain.amp_comp = 2'b00;
        next_st.gain.mixer_boost = st.filt[1];
      end
      AGC_MED: begin
        next_st.gain.amp_drive = st.low_noise_amplifier[3:2];
        next_st.gain.amp_reduced_gain = st.filt[2];
        next_st.gain.amp_comp = 2'b00;
        next_st.gain.mixer_boost = st.filt[0];
      end
      AGC_LOW: begin
        next_st.gain.amp_drive = st.low_noise_amplifier[1:0];
        next_st.gain.amp_reduced_gain = st.filt[3];
        next_st.gain.amp_comp = st.low_noise_amplifier[7:6];
        next_st.gain.mixer_boost = 1'b0;
      end
      default: begin
        // illegal code: keep the last applied settings
        next_st.gain = st.gain;
      end
    endcase
    // strobe processor data operations
    unique case (csp_op)
      OP_INC_Y: next_st.y = st.y + 8'd1;
      OP_DEC_Y: next_st.y = st.y - 8'd1;
      OP_INC_MAX_Y: begin
        // never climbs past the operand
        next_st.y = (st.y < csp_operand) ? st.y + 8'd1 : csp_operand;
      end
      OP_RAND_XY: next_st.y = csp_random & st.x;
      OP_DEC_Z: next_st.z = st.z - 8'd1;
      OP_NONE: next_st.y = st.y;
      default: next_st.y = st.y;
    endcase
    // countdown on timer overflow
    next_st.stop = 1'b0;
    dec_t = mac_overflow && csp_running && (st.t != T_NO_DEC);
    if (dec_t) begin
      if (st.t <= 8'd1) begin
        next_st.t = 8'h00;
        next_st.stop = 1'b1;
      end else begin
        next_st.t = st.t - 8'd1;
      end
    end
    // software writes, these win over hardware updates
    if (wr) begin
      unique case (paddr[17:2])
        IDX_LNA_MODE: next_st.low_noise_amplifier = d;
        IDX_FILT_GAIN: next_st.filt = d[5:0];
        IDX_MIXER: next_st.mix = d;
        IDX_SYN_HI: begin
          next_st.thr = d[POS_THR+:2];
          next_st.win_len = d[POS_WIN_LEN];
          next_st.word[9:8] = d[1:0];
        end
        IDX_SYN_LO: next_st.word[7:0] = d;
        IDX_CSP_X: next_st.x = d;
        IDX_CSP_Y: next_st.y = d;
        IDX_CSP_Z: next_st.z = d;
        IDX_CSP_CTRL: next_st.cpu_ctrl = d[0];
        IDX_CSP_T: begin
          next_st.t = d;
          next_st.stop = 1'b0;
        end
        default: next_st.t = next_st.t;
      endcase
    end
  end

  // ***************************************************
  // state register, frozen while ce is low
  // ***************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.low_noise_amplifier <= RST_LNA_MODE;
      st.filt <= RST_FILT_GAIN;
      st.mix <= RST_MIXER;
      st.thr <= RST_LOCK_COUNT_THRESHOLD;
      st.word <= {RST_WORD_HI, RST_WORD_LO};
      st.x <= RST_CSP;
      st.y <= RST_CSP;
      st.z <= RST_CSP;
      st.t <= RST_CSP;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ***************************************************
  // outputs
  // ***************************************************
  assign pready = ce && st.rd_ok; // zero wait states unless frozen
  assign prdata = st.prdata;
  assign pslverr = st.pslverr;
  assign lock_window = st.window;
  assign pll_locked = st.locked;
  assign rf_word = st.rf_word;
  assign lo_word = st.lo_word;
  assign gain = st.gain;
  assign csp_x = st.x;
  assign csp_y = st.y;
  assign csp_z = st.z;
  assign cpu_ctrl = st.cpu_ctrl;
  assign csp_stop = st.stop;
endmodule

// File: core/rfr_pkg.sv
// constants, types and state layout for the radio register bank
//
// Overview of operation
// - lock after 64/128/256/512 consecutive good windows
// - lock status bit reads current PLL lock
// - cal done clears at power-on, sets after cal
// - cal running high only while calibrating
// - lock window lasts 2 or 4 prescaler periods
// - rf frequency is 2048 plus 10-bit word
// - receive subtracts 2 MHz for local oscillator
// - countdown decrements on timer overflow while running
// - program stops when countdown is about to hit zero
// - countdown value 0xff disables decrement
// - x register feeds wait, random and conditional ops
// - y register changed by inc, dec, max, random
// - z register decremented by its op, tested by conditions
// - software cpu control bit feeds conditional ops
// - reserved bits read as zero
// - high-gain amplifier drive field maps four currents
// - amplifier reduced-gain bit follows gain mode
// - mixer boost bit follows gain mode
// - mixer drive field selects four currents
package rfr_pkg;
  // ***************************************************
  // register indexes, byte address is four times these
  // ***************************************************
  localparam logic [15:0] IDX_LNA_MODE = 16'hdf0d;
  localparam logic [15:0] IDX_FILT_GAIN = 16'hdf0e;
  localparam logic [15:0] IDX_MIXER = 16'hdf0f;
  localparam logic [15:0] IDX_SYN_HI = 16'hdf10;
  localparam logic [15:0] IDX_SYN_LO = 16'hdf11;
  localparam logic [15:0] IDX_CSP_X = 16'hdf12;
  localparam logic [15:0] IDX_CSP_Y = 16'hdf13;
  localparam logic [15:0] IDX_CSP_Z = 16'hdf14;
  localparam logic [15:0] IDX_CSP_CTRL = 16'hdf15;
  localparam logic [15:0] IDX_CSP_T = 16'hdf16;
  // ***************************************************
  // reset values
  // ***************************************************
  localparam logic [7:0] RST_LNA_MODE = 8'he5;
  localparam logic [5:0] RST_FILT_GAIN = 6'h2a;
  localparam logic [7:0] RST_MIXER = 8'h56;
  localparam logic [1:0] RST_LOCK_COUNT_THRESHOLD = 2'h1;
  localparam logic [1:0] RST_WORD_HI = 2'h1;
  localparam logic [7:0] RST_WORD_LO = 8'h65;
  localparam logic [7:0] RST_CSP = 8'h00;
  // ***************************************************
  // synth high register field positions
  // ***************************************************
  localparam int unsigned POS_THR = 6;
  localparam int unsigned POS_CAL_DONE = 5;
  localparam int unsigned POS_CAL_RUN = 4;
  localparam int unsigned POS_WIN_LEN = 3;
  localparam int unsigned POS_LOCKED = 2;
  // ***************************************************
  // counts
  // ***************************************************
  localparam logic [9:0] LOCK_BASE_PERIODS = 10'd64;
  localparam logic [2:0] WIN_SHORT = 3'd2;
  localparam logic [2:0] WIN_LONG = 3'd4;
  localparam logic [11:0] CHANNEL_WORD_BASE = 12'd2048;
  localparam logic [11:0] RX_LO_OFFSET = 12'd2;
  localparam logic [7:0] T_NO_DEC = 8'hff;

  // automatic gain control mode from the receiver
  typedef enum logic [1:0] {
    AGC_HIGH = 2'b00,
    AGC_MED = 2'b01,
    AGC_LOW = 2'b10
  } rfr_agc_t;

  // strobe processor data operations
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_INC_Y = 3'b001,
    OP_DEC_Y = 3'b010,
    OP_INC_MAX_Y = 3'b011,
    OP_RAND_XY = 3'b100,
    OP_DEC_Z = 3'b101
  } rfr_op_t;

  // settings handed to the analog receiver
  typedef struct packed {
    logic [1:0] amp_drive;
    logic amp_reduced_gain;
    logic [1:0] amp_comp;
    logic mixer_boost;
    logic [1:0] rx_mixer_drive;
    logic bpf_lo_cur;
    logic bpf_mid_cur;
  } rfr_gain_t;

  // whole block state
  typedef struct packed {
    logic [7:0] low_noise_amplifier;
    logic [5:0] filt;
    logic [7:0] mix;
    logic [1:0] thr;
    logic win_len;
    logic [9:0] word;
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] z;
    logic cpu_ctrl;
    logic [7:0] t;
    logic [2:0] ref_s;
    logic [2:0] pre_s;
    logic [1:0] ok_s;
    logic [1:0] on_s;
    logic [1:0] cal_s;
    logic on_d;
    logic [9:0] lock_cnt;
    logic locked;
    logic [2:0] win_cnt;
    logic window;
    logic cal_run;
    logic cal_done;
    logic [11:0] rf_word;
    logic [11:0] lo_word;
    rfr_gain_t gain;
    logic stop;
    logic [31:0] prdata;
    logic pslverr;
    logic rd_ok; // read data captured for the transfer in progress
  } rfr_state_t;
endpackage

// File: dv/rfr_regs_props.sv
// concurrent checks on the register bank ports
`timescale 1ns/10ps
module rfr_regs_props import rfr_pkg::*; (
  // clock, reset, bus
  input wire logic pclk, presetn, ce, psel, penable, pwrite,
  input wire logic [31:0] prdata,
  // radio side
  input wire logic receive_active, synth_on, pll_locked,
  input wire logic [11:0] rf_word, lo_word,
  // strobe processor side
  input wire logic csp_running, mac_overflow, csp_stop,
  input wire rfr_op_t csp_op,
  input wire logic [7:0] csp_x, csp_y, csp_z, csp_random
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // no software write this cycle, so an op is the only writer of x/y/z
  logic idle;
  assign idle = ce && csp_running && !(psel && penable && pwrite);
  AST_INCREMENT_Y_INSTR:
    assert property (idle && csp_op == OP_INC_Y |=> csp_y == $past(csp_y) + 8'h01)
      else $error("y increment wrong");
  AST_DECREMENT_Y_INSTR:
    assert property (idle && csp_op == OP_DEC_Y |=> csp_y == $past(csp_y) - 8'h01)
      else $error("y decrement wrong");
  AST_RANDOM_XY_INSTR:
    assert property (idle && csp_op == OP_RAND_XY |=> csp_y == ($past(csp_random) & $past(csp_x)))
      else $error("random y wrong");
  AST_DECREMENT_Z_INSTR:
    assert property (idle && csp_op == OP_DEC_Z |=> csp_z == $past(csp_z) - 8'h01)
      else $error("z decrement wrong");
  AST_HOLD:
    assert property (idle && csp_op == OP_NONE |=> $stable(csp_x) && $stable(csp_y) && $stable(csp_z))
      else $error("data register moved");
  AST_LO_RX:
    assert property (receive_active |=> lo_word == rf_word - 12'h002)
      else $error("receive offset missing");
  AST_LO_TX:
    assert property (!receive_active |=> lo_word == rf_word)
      else $error("transmit offset applied");
  AST_RF_BASE:
    assert property ($past(presetn) |-> rf_word[11:10] == 2'b10)
      else $error("rf word base wrong");
  AST_STOP_ONE:
    assert property (csp_stop |=> !csp_stop)
      else $error("stop longer than a cycle");
  AST_STOP_CAUSE:
    assert property (csp_stop |-> $past(mac_overflow) && $past(csp_running))
      else $error("stop without overflow");
  AST_RD_HI:
    assert property (prdata[31:8] == 24'h000000)
      else $error("upper read bits set");
  AST_LOCK_OFF:
    assert property (!synth_on [*4] |-> !pll_locked)
      else $error("lock held while off");
endmodule
bind rfr_regs rfr_regs_props PROPS (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .prdata,
  .receive_active, .synth_on, .pll_locked, .rf_word, .lo_word, .csp_running, .mac_overflow,
  .csp_stop, .csp_op, .csp_x, .csp_y, .csp_z, .csp_random);

// File: dv/rfr_synth_model.sv
// behavioural synthesizer: reference, prescaler, sync and calibration levels
`timescale 1ns/10ps
module rfr_synth_model (
  input wire logic pclk,
  input wire logic on,
  input wire logic good,
  input wire logic cal_req,
  output logic synth_on = 1'b0,
  output logic ref_clk_lvl = 1'b0,
  output logic sync_ok = 1'b0,
  output logic pre_clk_lvl = 1'b0,
  output logic cal_busy = 1'b0
);
  logic [3:0] ph = 4'h0; // reference is 16 pclk, prescaler 4 pclk
  int cal_n = 0;
  // clocks stand low while powered off, as the real oscillator does
  always @(posedge pclk) begin
    ph <= on ? ph + 4'h1 : 4'h0;
    synth_on <= on;
    ref_clk_lvl <= on && ph[3];
    pre_clk_lvl <= on && ph[1];
    sync_ok <= good;
    if (cal_req) begin
      cal_n <= 20;
    end else if (cal_n > 0) begin
      cal_n <= cal_n - 1;
    end
    cal_busy <= cal_n > 0;
  end
endmodule

// File: dv/rfr_regs_tb_top.sv
// self-checking bench for the radio register bank
`timescale 1ns/10ps
module rfr_regs_tb_top import rfr_pkg::*; ;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [17:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic [3:0] pstrb = 4'h1;
  logic pready, pslverr, lock_window, pll_locked, cpu_ctrl, csp_stop, a;
  logic synth_on, ref_clk_lvl, sync_ok, pre_clk_lvl, cal_busy, on = 0, good = 1, cal_req = 0;
  logic receive_active = 0, csp_running = 0, mac_overflow = 0;
  rfr_agc_t agc_mode = AGC_HIGH;
  rfr_op_t csp_op = OP_NONE;
  logic [7:0] csp_operand = 8'h80, csp_random = 8'h3c, csp_x, csp_y, csp_z;
  logic [11:0] rf_word, lo_word;
  rfr_gain_t gain;
  int num_errors = 0, check_count = 0;
  localparam int PRE_CYC = 4; // model prescaler period in pclk cycles
  // register map and reset image in one table
  logic [15:0] idx [10] = '{IDX_LNA_MODE, IDX_FILT_GAIN, IDX_MIXER, IDX_SYN_HI, IDX_SYN_LO,
    IDX_CSP_X, IDX_CSP_Y, IDX_CSP_Z, IDX_CSP_CTRL, IDX_CSP_T};
  logic [7:0] rv [10] = '{8'he5, 8'h2a, 8'h56, 8'h41, 8'h65, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [15:0] ey [5] = '{16'h0181, 16'h0180, 16'h0180, 16'h0118, 16'h0018};
  logic [7:0] fv [2] = '{8'h2a, 8'h15};
  always #10 pclk = ~pclk;
  rfr_regs DUT (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pready, .prdata, .pslverr, .synth_on, .ref_clk_lvl, .sync_ok, .pre_clk_lvl, .cal_busy,
    .lock_window, .pll_locked, .rf_word, .lo_word, .receive_active, .agc_mode, .gain,
    .csp_running, .mac_overflow, .csp_op, .csp_operand, .csp_random, .csp_x, .csp_y, .csp_z,
    .cpu_ctrl, .csp_stop);
  rfr_synth_model FAR (.pclk, .on, .good, .cal_req, .synth_on, .ref_clk_lvl, .sync_ok,
    .pre_clk_lvl, .cal_busy);
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, read data left in q; idle cycle after so psel is never re-driven
  task automatic rw(input logic w, input logic [15:0] i, input logic [7:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic ovf;
    mac_overflow <= 1;
    @(posedge pclk);
    mac_overflow <= 0;
  endtask
  // pclk edges at which the lock window is seen high, one whole pulse
  task automatic win_meas(output int n);
    n = 0;
    while (lock_window !== 1'b0) @(posedge pclk);
    while (lock_window !== 1'b1) @(posedge pclk);
    while (lock_window === 1'b1) begin
      n++;
      @(posedge pclk);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic t_regs;
    foreach (idx[k]) begin
      rw(0, idx[k], 0);
      chk(q, {24'h0, rv[k]});
    end
    chk(rf_word, 12'd2405);
    rw(1, IDX_FILT_GAIN, 8'hff);
    rw(0, IDX_FILT_GAIN, 0);
    chk(q, 32'h3f);
    rw(1, IDX_CSP_CTRL, 8'hff);
    rw(0, IDX_CSP_CTRL, 0);
    chk({q, cpu_ctrl}, 33'h003);
    rw(1, IDX_CSP_CTRL, 0);
    chk(cpu_ctrl, 0);
    rw(0, 16'hdf17, 0);
    chk({pslverr, q}, 33'h100000000);
    $display("register test done");
  endtask
  task automatic t_csp;
    rw(1, IDX_CSP_X, 8'h5a);
    rw(1, IDX_CSP_Y, 8'h80);
    rw(1, IDX_CSP_Z, 8'h01);
    csp_running <= 1;
    for (int k = 1; k < 6; k++) begin
      csp_op <= rfr_op_t'(k);
      @(posedge pclk);
      csp_op <= OP_NONE;
      @(posedge pclk);
      chk({csp_z, csp_y}, ey[k-1]);
    end
    rw(1, IDX_CSP_T, 8'h03);
    ovf();
    rw(0, IDX_CSP_T, 0);
    chk(q, 32'h02);
    rw(1, IDX_CSP_T, 8'hff);
    ovf();
    rw(0, IDX_CSP_T, 0);
    chk(q, 32'hff);
    rw(1, IDX_CSP_T, 8'h01);
    ovf();
    a = 0;
    repeat (3) @(posedge pclk) a |= csp_stop;
    rw(0, IDX_CSP_T, 0);
    chk({a, q}, 33'h100000000);
    rw(1, IDX_CSP_T, 8'h20);
    // one overflow pulse on the very edge at which the write lands
    fork
      rw(1, IDX_CSP_T, 8'h10);
      begin
        @(posedge pclk);
        ovf();
      end
    join
    rw(0, IDX_CSP_T, 0);
    chk(q, 32'h10);
    csp_running <= 0;
    $display("strobe processor test done");
  endtask
  task automatic t_gain;
    foreach (fv[j]) begin
      rw(1, IDX_FILT_GAIN, fv[j]);
      agc_mode <= AGC_LOW;
      repeat (2) @(posedge pclk);
      chk(gain.amp_reduced_gain, fv[j][3]);
      agc_mode <= AGC_MED;
      repeat (2) @(posedge pclk);
      chk({gain.amp_reduced_gain, gain.mixer_boost}, {fv[j][2], fv[j][0]});
      agc_mode <= AGC_HIGH;
      repeat (2) @(posedge pclk);
      chk({gain.mixer_boost, gain.amp_drive, gain.rx_mixer_drive}, {fv[j][1], 4'ha});
    end
    $display("gain test done");
  endtask
  task automatic t_synth;
    int n_short;
    int n_long;
    rw(1, IDX_SYN_HI, 8'h43);
    rw(1, IDX_SYN_LO, 8'hff);
    receive_active <= 1;
    repeat (2) @(posedge pclk);
    chk({rf_word, lo_word}, {12'd3071, 12'd3069});
    receive_active <= 0;
    on <= 1;
    cal_req <= 1;
    @(posedge pclk);
    cal_req <= 0;
    repeat (4) @(posedge pclk);
    rw(0, IDX_SYN_HI, 0);
    chk(q[5:4], 2'b01);
    repeat (30) @(posedge pclk);
    rw(0, IDX_SYN_HI, 0);
    chk(q[5:4], 2'b10);
    for (int c = 0; c < 4; c++) begin
      on <= 0;
      repeat (8) @(posedge pclk);
      rw(1, IDX_SYN_HI, {c[1:0], 6'h01});
      on <= 1;
      repeat ((64 << c) * 16 - 64) @(posedge pclk);
      rw(0, IDX_SYN_HI, 0);
      chk({q[5], q[2], pll_locked}, 0);
      repeat (96) @(posedge pclk);
      rw(0, IDX_SYN_HI, 0);
      chk({q[2], pll_locked}, 2'b11);
    end
    // window width in pclk: the long window is two prescaler periods longer
    win_meas(n_short);
    rw(1, IDX_SYN_HI, 8'hc9);
    win_meas(n_long);
    chk(n_short > PRE_CYC && n_short <= 2 * PRE_CYC, 1);
    chk(n_long - n_short, 2 * PRE_CYC);
    good <= 0; // a failed window must drop lock
    repeat (40) @(posedge pclk);
    chk(pll_locked, 0);
    $display("synthesizer test done");
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_regs();
    t_csp();
    t_gain();
    t_synth();
    stop_test();
  end
  // watchdog well beyond the roughly 16000 cycles the tests need
  initial begin
    repeat (40000) @(posedge pclk);
    num_errors++;
    stop_test();
  end
endmodule
